/* File: hdl/sap_pkg.sv */
// Shared constants, register map and field layout of the serial audio port control/status block.
// What this block does
// - Control/status register is 16 bits: upper byte setup, lower byte read-only flags.
// - Visible flags update only while enabled, after first bit of next word.
// - Bypass set: prescaler runs at bus clock; clear: bus clock divided by four.
// - Receive bit order bit clear takes MSB first, set takes LSB first.
// - Receive clock polarity: 1 latches on rising edge, 0 on falling.
// - Receive sync polarity bit: 1 makes sync active low, 0 active high.
// - Receive sync length: 1 gives one bit, 0 gives one word.
// - Early sync starts one bit before data; otherwise with first data bit.
// - Early sync ends after one bit or one word, per length choice.
// - Data ready sets on new receive value; cleared by read or empty queue, resets.
// - Overrun never interrupts; it selects the exception receive vector.
// - Transmit empty set when the holding word moves to the shifter, or while the queue has room; resets set it.
// - Transmit write clears empty when no queue is used; enabled flag interrupts, exception vector on underrun.
// - Overrun sets when a word completes into a full store; word dropped.
// - Overrun clears by reset, or status read then holding read; not by receive disable.
// - Transmit slot with empty holding sets underrun and repeats the last word.
// - Transmit slot is frame sync in normal mode, every slot in network mode.
// - Underrun clears by reset, or status read then transmit holding write.
// - Network mode frame flags set in first slot, cleared at next slot, resets.
// - Receive watermark flag at threshold; cleared by read or disable; full queue drops.
// - Transmit watermark flag below threshold; cleared at threshold; reset sets it.
// - Word size selects 8, 10, 12 or 16 bits, also the word-long sync.
package sap_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  ADDR_STATUS   = 4'h0;
  localparam logic [3:0]  ADDR_CONFIG   = 4'h4;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Setup byte positions within the control/status register.
  localparam int B_BYPASS   = 15;
  localparam int B_LSBFIRST = 14;
  localparam int B_RISING   = 13;
  localparam int B_RXDMA    = 12;
  localparam int B_TXDMA    = 11;
  localparam int B_SYNCLOW  = 10;
  localparam int B_SYNCBIT  = 9;
  localparam int B_EARLY    = 8;
  // Status byte positions.
  localparam int F_RDY  = 7;
  localparam int F_TDE  = 6;
  localparam int F_OVR  = 5;
  localparam int F_UND  = 4;
  localparam int F_TFS  = 3;
  localparam int F_RFS  = 2;
  localparam int F_RWM  = 1;
  localparam int F_TWM  = 0;
  // Configuration register positions.
  localparam int C_EN    = 0;
  localparam int C_RXEN  = 1;
  localparam int C_RXQ   = 2;
  localparam int C_TXQ   = 3;
  localparam int C_RIE   = 4;
  localparam int C_TIE   = 5;
  localparam int C_NET   = 6;
  localparam int C_RST   = 7;
  localparam int C_WL    = 8;
  localparam int C_RTHR  = 10;
  localparam int C_TTHR  = 14;
  localparam int CFG_W   = 18;
  // ---------------------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0]       SETUP_RST  = 8'h00;
  localparam logic [7:0]       FLAGS_RST  = 8'h41;
  localparam logic [CFG_W-1:0] CFG_RST    = 18'h2_2000;
  localparam logic [1:0]       FIX_DIV_LAST = 2'h3;
  // Word size in bits for each select code.
  function automatic logic [4:0] sap_word_bits(input logic [1:0] sel);
    case (sel)
      2'h0:    sap_word_bits = 5'h08;
      2'h1:    sap_word_bits = 5'h0a;
      2'h2:    sap_word_bits = 5'h0c;
      default: sap_word_bits = 5'h10;
    endcase
  endfunction : sap_word_bits
endpackage : sap_pkg

/* File: hdl/sap_rx_sync.sv */
// Receive frame sync shaper: polarity, length and early timing.
`timescale 1ns/100ps
module sap_rx_sync
  import sap_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       bit_en,
  input  wire logic       word_start,
  input  wire logic       bit_length,
  input  wire logic       early,
  input  wire logic       active_low,
  input  wire logic [4:0] word_bits,
  output logic            sync_q
);
  typedef struct packed {
    logic       pending;
    logic       active;
    logic [4:0] cnt;
    logic       sync;
  } sap_sync_type;
  sap_sync_type s_q, s_d;
  logic [4:0]   len_m1;

  // Length minus one: one bit or one full word.
  assign len_m1 = bit_length ? 5'h00 : 5'(word_bits - 5'h01);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Word start marks the lead bit; late sync waits one bit for the data.
  always_comb begin
    s_d = s_q;
    if (bit_en) begin
      if (word_start && early) begin
        s_d.active  = 1'b1;
        s_d.cnt     = len_m1;
        s_d.pending = 1'b0;
      end else if (word_start) begin
        s_d.pending = 1'b1;
      end else if (s_q.pending) begin
        s_d.pending = 1'b0;
        s_d.active  = 1'b1;
        s_d.cnt     = len_m1;
      end else if (s_q.active) begin
        if (s_q.cnt == 5'h00) begin
          s_d.active = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
    end
    s_d.sync = s_d.active ^ active_low;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_q = s_q.sync;

  property p_bit_sync;
    @(posedge aclk) disable iff (!aresetn)
      $rose(s_q.active) && bit_length |-> s_q.cnt == 5'h00;
  endproperty
  a_bit_sync: assert property (p_bit_sync) else $error("bit-length sync loaded with a long count");

  property p_early;
    @(posedge aclk) disable iff (!aresetn)
      bit_en && word_start && early |=> s_q.active;
  endproperty
  a_early: assert property (p_early) else $error("early sync did not start on the lead bit");
endmodule : sap_rx_sync

/* File: hdl/sap_port.sv */
// Control/status register, flag logic and register bus slave of the serial audio port.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module sap_port
  import sap_pkg::*;
#(
  parameter int QDEPTH = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        word_first_bit_done,
  input  wire logic        rx_word_complete,
  input  wire logic        rx_holding_read,
  input  wire logic [3:0]  rx_queue_level,
  input  wire logic        tx_holding_write,
  input  wire logic        tx_holding_to_shifter,
  input  wire logic [3:0]  tx_queue_level,
  input  wire logic        tx_frame_sync,
  input  wire logic        tx_slot_start,
  input  wire logic        tx_first_slot,
  input  wire logic        rx_slot_start,
  input  wire logic        rx_first_slot,
  input  wire logic        bit_clock_en,
  input  wire logic        rx_word_start,
  output logic             fix_clk_en_q,
  output logic             rx_lsb_first_q,
  output logic             rx_clock_rising_edge_q,
  output logic             rx_store_q,
  output logic             tx_repeat_q,
  output logic             rx_sync_q,
  output logic             rx_irq_exception_q,
  output logic             rx_irq_normal_q,
  output logic             tx_irq_exception_q,
  output logic             tx_irq_normal_q
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic             aw_rdy;
    logic             w_rdy;
    logic             aw_got;
    logic             w_got;
    logic [3:0]       waddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             ar_rdy;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [7:0]       setup;
    logic [CFG_W-1:0] cfg;
    logic [7:0]       raw;
    logic [7:0]       vis;
    logic             arm_ovr;
    logic             arm_und;
    logic [1:0]       div;
    logic             fix_en;
    logic             store;
    logic             repeat_w;
    logic             rx_exc;
    logic             rx_norm;
    logic             tx_exc;
    logic             tx_norm;
  } sap_state_type;
  sap_state_type st_q, st_d;

  logic             en, rxq, txq, net, prst;
  logic [3:0]       rthr, tthr;
  logic             rx_full, tx_slot, status_rd;
  logic [31:0]      wmask, wr_val;
  logic [7:0]       set_v, clr_v;

  assign en   = st_q.cfg[C_EN];
  assign rxq  = st_q.cfg[C_RXQ];
  assign txq  = st_q.cfg[C_TXQ];
  assign net  = st_q.cfg[C_NET];
  assign prst = st_q.cfg[C_RST];
  assign rthr = st_q.cfg[C_RTHR +: 4];
  assign tthr = st_q.cfg[C_TTHR +: 4];

  // Store is full when the holding register is unread or the queue has no room.
  assign rx_full = rxq ? (32'(rx_queue_level) >= QDEPTH) : st_q.raw[F_RDY];
  // Normal mode slots are frame syncs; every slot counts in network mode.
  assign tx_slot = net ? tx_slot_start : tx_frame_sync;
  assign status_rd = s_axi_arvalid && st_q.ar_rdy && (s_axi_araddr == ADDR_STATUS);
  assign wmask = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}}, {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Flags are kept twice: raw tracks events at once, the visible copy follows
  // it only at the word update point, so software sees stable words.
  always_comb begin
    st_d   = st_q;
    wr_val = 32'h0000_0000;
    set_v  = 8'h00;
    clr_v  = 8'h00;

    // Write channel: address and data taken in either order.
    if (s_axi_awvalid && st_q.aw_rdy) begin
      st_d.aw_got = 1'b1;
      st_d.aw_rdy = 1'b0;
      st_d.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.w_rdy) begin
      st_d.w_got = 1'b1;
      st_d.w_rdy = 1'b0;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = RESP_OKAY;
      if (st_q.waddr == ADDR_STATUS) begin
        // Only the setup byte takes writes; the status byte keeps its flags.
        wr_val = (st_q.wdata & wmask) | ({16'h0000, st_q.setup, 8'h00} & ~wmask);
        st_d.setup = wr_val[15:8];
      end else if (st_q.waddr == ADDR_CONFIG) begin
        wr_val = (st_q.wdata & wmask) | (32'(st_q.cfg) & ~wmask);
        st_d.cfg = wr_val[CFG_W-1:0];
      end else begin
        st_d.bresp = RESP_SLVERR;
      end
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
      st_d.aw_rdy = 1'b1;
      st_d.w_rdy  = 1'b1;
    end

    // Read channel.
    if (s_axi_arvalid && st_q.ar_rdy) begin
      st_d.ar_rdy = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rresp  = RESP_OKAY;
      if (s_axi_araddr == ADDR_STATUS) begin
        st_d.rdata = {16'h0000, st_q.setup, st_q.vis};
      end else if (s_axi_araddr == ADDR_CONFIG) begin
        st_d.rdata = 32'(st_q.cfg);
      end else begin
        st_d.rdata = 32'h0000_0000;
        st_d.rresp = RESP_SLVERR;
      end
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
      st_d.ar_rdy = 1'b1;
    end

    // Fixed prescaler enable: every cycle, or one in four.
    st_d.fix_en = st_q.setup[B_BYPASS - 8] || (st_q.div == FIX_DIV_LAST);
    st_d.div    = st_q.setup[B_BYPASS - 8] ? 2'h0 : 2'(st_q.div + 2'h1);

    // Event pulses towards the data path.
    st_d.store    = rx_word_complete && st_q.cfg[C_RXEN] && !rx_full;
    st_d.repeat_w = tx_slot && st_q.raw[F_TDE];

    // Set and clear terms of each raw flag.
    set_v[F_RDY] = rx_word_complete && st_q.cfg[C_RXEN] && !rx_full;
    clr_v[F_RDY] = rxq ? (rx_queue_level == 4'h0) : rx_holding_read;
    set_v[F_TDE] = txq ? (32'(tx_queue_level) < QDEPTH) : tx_holding_to_shifter;
    clr_v[F_TDE] = tx_holding_write;
    set_v[F_OVR] = rx_word_complete && st_q.cfg[C_RXEN] && rx_full;
    clr_v[F_OVR] = st_q.arm_ovr && rx_holding_read;
    set_v[F_UND] = tx_slot && st_q.raw[F_TDE];
    clr_v[F_UND] = st_q.arm_und && tx_holding_write;
    set_v[F_TFS] = net && tx_slot_start && tx_first_slot;
    clr_v[F_TFS] = !net || tx_slot_start;
    set_v[F_RFS] = net && rx_slot_start && rx_first_slot;
    clr_v[F_RFS] = !net || rx_slot_start;
    set_v[F_RWM] = rxq && (rx_queue_level >= rthr);
    clr_v[F_RWM] = rx_holding_read || !en;
    set_v[F_TWM] = !en || (txq && (tx_queue_level < tthr));
    clr_v[F_TWM] = tx_queue_level >= tthr;

    // A set in the same cycle as its clear wins.
    st_d.raw = (st_q.raw & ~clr_v) | set_v;
    // The queue-backed empty flag follows the queue level directly.
    if (txq) begin
      st_d.raw[F_TDE] = set_v[F_TDE];
    end

    // Visible copy: loaded at the update point, clears take effect at once.
    if (en && word_first_bit_done) begin
      st_d.vis = st_d.raw;
    end else begin
      st_d.vis = st_q.vis & ~(clr_v & ~set_v);
    end

    // Arming: a status read seen with the flag up, held until the data access.
    if (status_rd && st_q.vis[F_OVR]) begin
      st_d.arm_ovr = 1'b1;
    end else if (clr_v[F_OVR] || !st_q.raw[F_OVR]) begin
      st_d.arm_ovr = 1'b0;
    end
    if (status_rd && st_q.vis[F_UND]) begin
      st_d.arm_und = 1'b1;
    end else if (clr_v[F_UND] || !st_q.raw[F_UND]) begin
      st_d.arm_und = 1'b0;
    end

    // Port reset returns flags to their reset values; setup and config stay.
    if (prst) begin
      st_d.raw     = FLAGS_RST;
      st_d.vis     = FLAGS_RST;
      st_d.arm_ovr = 1'b0;
      st_d.arm_und = 1'b0;
    end

    // Interrupt requests; overrun and underrun only steer the vector.
    st_d.rx_exc  = st_q.cfg[C_RIE] && st_q.cfg[C_RXEN] &&
                   (rxq ? st_q.vis[F_RWM] : st_q.vis[F_RDY]) && st_q.vis[F_OVR];
    st_d.rx_norm = st_q.cfg[C_RIE] && st_q.cfg[C_RXEN] &&
                   (rxq ? st_q.vis[F_RWM] : st_q.vis[F_RDY]) && !st_q.vis[F_OVR];
    st_d.tx_exc  = st_q.cfg[C_TIE] &&
                   (txq ? st_q.vis[F_TWM] : st_q.vis[F_TDE]) && st_q.vis[F_UND];
    st_d.tx_norm = st_q.cfg[C_TIE] &&
                   (txq ? st_q.vis[F_TWM] : st_q.vis[F_TDE]) && !st_q.vis[F_UND];
  end

  // Single register stage for all state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= '0;
      st_q.aw_rdy <= 1'b1;
      st_q.w_rdy  <= 1'b1;
      st_q.ar_rdy <= 1'b1;
      st_q.setup  <= SETUP_RST;
      st_q.cfg    <= CFG_RST;
      st_q.raw    <= FLAGS_RST;
      st_q.vis    <= FLAGS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Receive frame sync and outputs
  // ---------------------------------------------------------------------------
  sap_rx_sync u_rx_sync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .bit_en     (bit_clock_en),
    .word_start (rx_word_start),
    .bit_length (st_q.setup[B_SYNCBIT - 8]),
    .early      (st_q.setup[B_EARLY - 8]),
    .active_low (st_q.setup[B_SYNCLOW - 8]),
    .word_bits  (sap_word_bits(st_q.cfg[C_WL +: 2])),
    .sync_q     (rx_sync_q)
  );

  assign s_axi_awready          = st_q.aw_rdy;
  assign s_axi_wready           = st_q.w_rdy;
  assign s_axi_bresp            = st_q.bresp;
  assign s_axi_bvalid           = st_q.bvalid;
  assign s_axi_arready          = st_q.ar_rdy;
  assign s_axi_rdata            = st_q.rdata;
  assign s_axi_rresp            = st_q.rresp;
  assign s_axi_rvalid           = st_q.rvalid;
  assign fix_clk_en_q           = st_q.fix_en;
  assign rx_lsb_first_q         = st_q.setup[B_LSBFIRST - 8];
  assign rx_clock_rising_edge_q = st_q.setup[B_RISING - 8];
  assign rx_store_q             = st_q.store;
  assign tx_repeat_q            = st_q.repeat_w;
  assign rx_irq_exception_q     = st_q.rx_exc;
  assign rx_irq_normal_q        = st_q.rx_norm;
  assign tx_irq_exception_q     = st_q.tx_exc;
  assign tx_irq_normal_q        = st_q.tx_norm;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_div_bypass;
    @(posedge aclk) disable iff (!aresetn) st_q.setup[B_BYPASS - 8] |=> st_q.fix_en;
  endproperty
  a_div_bypass: assert property (p_div_bypass) else $error("bypass did not pass every cycle");

  property p_div_four;
    @(posedge aclk) disable iff (!aresetn)
      st_q.fix_en && !st_q.setup[B_BYPASS - 8] && !st_d.setup[B_BYPASS - 8] |=> !st_q.fix_en;
  endproperty
  a_div_four: assert property (p_div_four) else $error("divided enable ran back to back");

  property p_overrun_drop;
    @(posedge aclk) disable iff (!aresetn)
      rx_word_complete && st_q.cfg[C_RXEN] && rx_full && !prst |=> !rx_store_q && st_q.raw[F_OVR];
  endproperty
  a_overrun_drop: assert property (p_overrun_drop) else $error("overrun word was stored");

  property p_rx_vector;
    @(posedge aclk) disable iff (!aresetn) rx_irq_exception_q |-> $past(st_q.vis[F_OVR]) && !rx_irq_normal_q;
  endproperty
  a_rx_vector: assert property (p_rx_vector) else $error("receive exception vector without overrun");

  property p_tx_write_clears;
    @(posedge aclk) disable iff (!aresetn)
      tx_holding_write && !txq && !tx_holding_to_shifter && !prst |=> !st_q.raw[F_TDE];
  endproperty
  a_tx_write_clears: assert property (p_tx_write_clears) else $error("write did not clear transmit empty");

  property p_underrun;
    @(posedge aclk) disable iff (!aresetn)
      tx_slot && st_q.raw[F_TDE] && !prst |=> st_q.raw[F_UND] && tx_repeat_q;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun missed on empty slot");

  property p_update_gate;
    @(posedge aclk) disable iff (!aresetn)
      (st_q.vis & ~$past(st_q.vis)) != 8'h00 |-> $past(en && word_first_bit_done) || $past(prst);
  endproperty
  a_update_gate: assert property (p_update_gate) else $error("visible flag rose outside update point");

  property p_overrun_clear;
    @(posedge aclk) disable iff (!aresetn)
      $fell(st_q.raw[F_OVR]) |-> $past(st_q.arm_ovr && rx_holding_read) || $past(prst);
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun cleared without sequence");

  property p_ready_on_store;
    @(posedge aclk) disable iff (!aresetn) rx_store_q && !$past(prst) |-> st_q.raw[F_RDY];
  endproperty
  a_ready_on_store: assert property (p_ready_on_store) else $error("stored word without data ready");
endmodule : sap_port

/* File: bench/sap_codec_model.sv */
// Codec-side model: turns bench requests into one-cycle link events.
`timescale 1ns/100ps
module sap_codec_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] ev,
  output logic [7:0]      pulse_q,
  output logic            bit_tick_q
);
  // Events leave one cycle after the request; the bit tick runs free at half rate.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_q    <= 8'h00;
      bit_tick_q <= 1'b0;
    end else begin
      pulse_q    <= ev;
      bit_tick_q <= ~bit_tick_q;
    end
  end
endmodule : sap_codec_model

/* File: bench/testbench.sv */
// Register-level bench of the serial audio port control/status block.
`timescale 1ns/100ps
module testbench;
  import sap_pkg::*;
  logic aclk, aresetn, awv, wv, bready, arv, rready, awr, wr_r, bv, arr, rv, fix, lsb, rise, rep, rxe, txe;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic [7:0] ev, p;
  logic tick, ws, si, ld, sy, sto, rxn, txn;
  int failures, total_checks, fix_n, rep_n, syn_n, lead_n, st_n;
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  // The codec model supplies the link pulses and bit tick; ws gives word start; queue levels and slot positions stay idle.
  sap_codec_model i_codec (.aclk(aclk), .aresetn(aresetn), .ev(ev), .pulse_q(p), .bit_tick_q(tick));
  sap_port i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .word_first_bit_done(p[0]), .rx_word_complete(p[1]), .rx_holding_read(p[2]), .rx_queue_level(4'h0),
    .tx_holding_write(p[3]), .tx_holding_to_shifter(p[4]), .tx_queue_level(4'h0), .tx_frame_sync(p[5]),
    .tx_slot_start(p[6]), .tx_first_slot(1'b0), .rx_slot_start(p[7]), .rx_first_slot(1'b0),
    .bit_clock_en(tick), .rx_word_start(ws && tick), .fix_clk_en_q(fix), .rx_lsb_first_q(lsb),
    .rx_clock_rising_edge_q(rise), .rx_store_q(sto), .tx_repeat_q(rep), .rx_sync_q(sy), .rx_irq_exception_q(rxe),
    .rx_irq_normal_q(rxn), .tx_irq_exception_q(txe), .tx_irq_normal_q(txn));
  // Pulse counters let a check span a window without racing the edge.
  always @(posedge aclk) begin
    if (fix === 1'b1) fix_n++;
    if (rep === 1'b1) rep_n++;
    if (sto === 1'b1) st_n++;
    if (sy === ~si) syn_n++;
    if (ld && sy === ~si) lead_n++;
    ld <= ws && tick;
  end
  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // Handshakes are sampled mid-cycle, so a release lands right after the taking edge.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bit ta, tw, tb;
    int n;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awv <= 1; wv <= 1; bready <= 1; n = 0;
    do begin
      #1; ta = awv && awr; tw = wv && wr_r; tb = (bv === 1'b1);
      @(posedge aclk); n++;
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!tb && n < 50);
    bready <= 0;
    if (n >= 50) begin failures++; close_out(); end
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    bit ta, tr;
    int n;
    @(posedge aclk);
    araddr <= a; arv <= 1; rready <= 1; n = 0;
    do begin
      #1; ta = arv && arr; tr = (rv === 1'b1); v = rdata; r = rresp;
      @(posedge aclk); n++;
      if (ta) arv <= 0;
    end while (!tr && n < 50);
    rready <= 0;
    if (n >= 50) begin failures++; close_out(); end
  endtask : rd
  // The lead-bit request stands for two clocks, so it meets exactly one bit tick.
  task automatic sync_run;
    #1 syn_n = 0; lead_n = 0;
    @(posedge aclk); ws <= 1;
    repeat (2) @(posedge aclk);
    ws <= 0;
    repeat (24) @(posedge aclk);
    #1;
  endtask : sync_run
  task automatic fire(input logic [7:0] e);
    @(posedge aclk); ev <= e;
    @(posedge aclk); ev <= 8'h00;
    repeat (3) @(posedge aclk);
  endtask : fire
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [1:0] r;
    aresetn = 0; awv = 0; wv = 0; bready = 0; arv = 0; rready = 0; ev = 0;
    awaddr = 0; araddr = 0; wdata = 0; failures = 0; total_checks = 0; ws = 0; si = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(ADDR_STATUS, d, r); chk(d, 32'h0000_0041);
    wr(ADDR_STATUS, 32'hffff_e7ff);
    rd(ADDR_STATUS, d, r); chk(d, 32'h0000_e741);
    chk({lsb, rise}, 2'h3);
    #1 fix_n = 0; repeat (8) @(posedge aclk); #1 chk(fix_n, 8);
    wr(ADDR_STATUS, 32'h0000_0000);
    #1 fix_n = 0; repeat (8) @(posedge aclk); #1 chk(fix_n, 2);
    rd(4'h8, d, r); chk({r, d}, {RESP_SLVERR, 32'h0000_0000});
    $display("setup test done");
    wr(ADDR_CONFIG, 32'h0002_2013);
    fire(8'h02); fire(8'h02); chk(st_n, 1);
    rd(ADDR_STATUS, d, r); chk(d & 32'h0000_00a0, 32'h0000_0000);
    fire(8'h01);
    rd(ADDR_STATUS, d, r); chk(d & 32'h0000_00a0, 32'h0000_00a0);
    chk({rxe, rxn}, 2'h2);
    fire(8'h04); fire(8'h01);
    rd(ADDR_STATUS, d, r); chk(d & 32'h0000_00a0, 32'h0000_0000);
    $display("overrun test done");
    wr(ADDR_CONFIG, 32'h0002_2021);
    #1 rep_n = 0; fire(8'h20); chk(rep_n, 1);
    fire(8'h01);
    rd(ADDR_STATUS, d, r); chk(d & 32'h0000_0050, 32'h0000_0050);
    chk({txe, txn}, 2'h2);
    fire(8'h08); fire(8'h01);
    rd(ADDR_STATUS, d, r); chk(d & 32'h0000_0050, 32'h0000_0000);
    $display("underrun test done");
    wr(ADDR_STATUS, 32'h0000_0300); si = 0; sync_run();
    chk(syn_n, 2);
    chk(lead_n, 1);
    wr(ADDR_STATUS, 32'h0000_0400); si = 1; sync_run();
    chk(syn_n, 16);
    chk(lead_n, 0);
    $display("sync test done");
    close_out();
  end
endmodule : testbench
